// >>> inc/lrs_pkg.sv
// Functional notes
// - 3-bit source select: one control input, inputs 3 and 4, or one.
// - Shared rail good gates rail two unless its mask bit is set.
// - Register bit 0 set drops load switch b one good from rail two.
// - Rail-two rising edge delayed by code: 0,2,4,8,16,24,32,64 ms.
// - Rail-two falling edge delayed by same table; code 110 means 32 ms.
// - Rail one held off during shutdown for 1, 5, 10 or 100 ms.
// - Rail-three mask: bits 0-5 step-down, bit 6 switch a, bit 7 rail two.
package lrs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LDO_TWO_PIN = 8'h1d;
  localparam logic [7:0] ADDR_LDO_TWO_DLY = 8'h1e;
  localparam logic [7:0] ADDR_LDO_THREE_MASK = 8'h1f;
  localparam logic [7:0] ADDR_STATUS = 8'h30;

  localparam logic [7:0] RST_LDO_TWO_PIN = 8'h40;
  localparam logic [7:0] RST_LDO_TWO_DLY = 8'h00;
  localparam logic [7:0] RST_LDO_THREE_MASK = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SWITCH_ONE_MASK_BIT = 0;
  localparam int SHARED_MASK_BIT = 1;
  localparam int SRC_SEL_LSB = 2;
  localparam int RISE_LSB = 0;
  localparam int FALL_LSB = 3;
  localparam int OFF_TIME_LSB = 6;
  localparam int STAT_LDO_TWO_BIT = 0;
  localparam int STAT_LDO_ONE_BIT = 1;
  localparam int STAT_LDO_THREE_OK_BIT = 2;
  localparam int STAT_REQ_BIT = 3;

  // Synchronised pin vector layout
  localparam int PIN_CTL_LSB = 0;
  localparam int PIN_SHARED_GOOD = 6;
  localparam int PIN_LOAD_SWITCH_B_ONE_GOOD = 7;
  localparam int PIN_STEP_LSB = 8;
  localparam int PIN_SWA_GOOD = 14;
  localparam int PIN_LDO2_GOOD = 15;
  localparam int PIN_LDO1_REQ = 16;
  localparam int PIN_W = 17;

  // ----------------------------------------------------------------
  // Enable source codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LRS_SRC_CONTROL_INPUT_1, LRS_SRC_CONTROL_INPUT_2, LRS_SRC_CONTROL_INPUT_5, LRS_SRC_CONTROL_INPUT_4,
    LRS_SRC_CONTROL_INPUT_3, LRS_SRC_CTL34, LRS_SRC_CONTROL_INPUT_6, LRS_SRC_ONE
  } lrs_src_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam int MS_W = 7;
  localparam int SUB_W = 15;

  // Edge delay table in ms
  function automatic logic [6:0] lrs_edge_ms(input logic [2:0] code);
    unique case (code)
      3'h0: lrs_edge_ms = 7'h00;
      3'h1: lrs_edge_ms = 7'h02;
      3'h2: lrs_edge_ms = 7'h04;
      3'h3: lrs_edge_ms = 7'h08;
      3'h4: lrs_edge_ms = 7'h10;
      3'h5: lrs_edge_ms = 7'h18;
      3'h6: lrs_edge_ms = 7'h20;
      3'h7: lrs_edge_ms = 7'h40;
    endcase
  endfunction : lrs_edge_ms

  // Rail-one shutdown off time in ms
  function automatic logic [6:0] lrs_off_ms(input logic [1:0] code);
    unique case (code)
      2'h0: lrs_off_ms = 7'h01;
      2'h1: lrs_off_ms = 7'h05;
      2'h2: lrs_off_ms = 7'h0a;
      2'h3: lrs_off_ms = 7'h64;
    endcase
  endfunction : lrs_off_ms

endpackage : lrs_pkg

// >>> rtl/lrs_edge_delay.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Level follower with separate rise and fall delays in ms
// ------------------------------------------------------------------
module lrs_edge_delay #(
  parameter int MS_CYCLES = lrs_pkg::MS_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic level_in,
  input wire logic [6:0] rise_ms,
  input wire logic [6:0] fall_ms,
  output logic level_out
);

  localparam logic [14:0] SUB_LAST = 15'(MS_CYCLES - 1);

  logic out_reg, out_next;
  logic [14:0] sub_reg, sub_next;
  logic [6:0] ms_reg, ms_next;
  logic [6:0] target;

  // Timer restarts whenever input and output agree again, so a glitch
  // shorter than the delay never reaches the rail
  always_comb begin
    out_next = out_reg;
    sub_next = sub_reg;
    ms_next = ms_reg;
    target = level_in ? rise_ms : fall_ms;
    if (level_in == out_reg) begin
      sub_next = '0;
      ms_next = '0;
    end else if (ms_reg >= target) begin
      out_next = level_in;
      sub_next = '0;
      ms_next = '0;
    end else if (sub_reg == SUB_LAST) begin
      sub_next = '0;
      ms_next = ms_reg + 7'h01;
    end else begin
      sub_next = sub_reg + 15'h0001;
    end
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_reg <= 1'b0;
      sub_reg <= '0;
      ms_reg <= '0;
    end else begin
      out_reg <= out_next;
      sub_reg <= sub_next;
      ms_reg <= ms_next;
    end
  end

  assign level_out = out_reg;

endmodule : lrs_edge_delay

// >>> rtl/lrs_top.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Enable sequencing for rails one and two, good qualification for rail three
// ------------------------------------------------------------------
module lrs_top #(
  parameter int MS_CYCLES = lrs_pkg::MS_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] control_input,
  input wire logic shared_rail_good,
  input wire logic switch_b_one_good,
  input wire logic [5:0] step_down_good,
  input wire logic switch_a_good,
  input wire logic ldo_two_good,
  input wire logic ldo_one_request,
  output logic ldo_two_enable,
  output logic ldo_one_enable,
  output logic ldo_three_goods_ok
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [16:0] pin_raw;
  logic [16:0] meta_reg, meta_next;
  logic [16:0] pin_reg, pin_next;

  assign pin_raw = {ldo_one_request, ldo_two_good, switch_a_good,
                    step_down_good, switch_b_one_good, shared_rail_good,
                    control_input};

  // First stage feeds only the second stage
  always_comb begin
    meta_next = pin_raw;
    pin_next = meta_reg;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      pin_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      pin_reg <= pin_next;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] pin_cfg_reg, pin_cfg_next;
  logic [7:0] dly_cfg_reg, dly_cfg_next;
  logic [7:0] mask_cfg_reg, mask_cfg_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] status;

  // Writes land in one cycle; reserved bits are kept as written
  always_comb begin
    pin_cfg_next = pin_cfg_reg;
    dly_cfg_next = dly_cfg_reg;
    mask_cfg_next = mask_cfg_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        lrs_pkg::ADDR_LDO_TWO_PIN: pin_cfg_next = reg_wdata;
        lrs_pkg::ADDR_LDO_TWO_DLY: dly_cfg_next = reg_wdata;
        lrs_pkg::ADDR_LDO_THREE_MASK: mask_cfg_next = reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data valid the cycle after the strobe only
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        lrs_pkg::ADDR_LDO_TWO_PIN: rdata_next = pin_cfg_reg;
        lrs_pkg::ADDR_LDO_TWO_DLY: rdata_next = dly_cfg_reg;
        lrs_pkg::ADDR_LDO_THREE_MASK: rdata_next = mask_cfg_reg;
        lrs_pkg::ADDR_STATUS: rdata_next = status;
        default: rdata_next = 8'h00; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_cfg_reg <= lrs_pkg::RST_LDO_TWO_PIN;
      dly_cfg_reg <= lrs_pkg::RST_LDO_TWO_DLY;
      mask_cfg_reg <= lrs_pkg::RST_LDO_THREE_MASK;
      rdata_reg <= 8'h00;
    end else begin
      pin_cfg_reg <= pin_cfg_next;
      dly_cfg_reg <= dly_cfg_next;
      mask_cfg_reg <= mask_cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Rail two request
  // ----------------------------------------------------------------
  logic [5:0] ctl;
  lrs_pkg::lrs_src_t src_sel;
  logic src_level;
  logic shared_ok, switch_one_ok;
  logic req_reg, req_next;

  assign ctl = pin_reg[lrs_pkg::PIN_CTL_LSB +: 6];
  assign src_sel = lrs_pkg::lrs_src_t'(pin_cfg_reg[lrs_pkg::SRC_SEL_LSB +: 3]);

  // Source mux; code one needs no pin at all
  always_comb begin
    unique case (src_sel)
      lrs_pkg::LRS_SRC_CONTROL_INPUT_1: src_level = ctl[0];
      lrs_pkg::LRS_SRC_CONTROL_INPUT_2: src_level = ctl[1];
      lrs_pkg::LRS_SRC_CONTROL_INPUT_5: src_level = ctl[4];
      lrs_pkg::LRS_SRC_CONTROL_INPUT_4: src_level = ctl[3];
      lrs_pkg::LRS_SRC_CONTROL_INPUT_3: src_level = ctl[2];
      lrs_pkg::LRS_SRC_CTL34: src_level = ctl[2] & ctl[3];
      lrs_pkg::LRS_SRC_CONTROL_INPUT_6: src_level = ctl[5];
      lrs_pkg::LRS_SRC_ONE: src_level = 1'b1;
    endcase
  end

  // A set mask bit forces its good term true
  assign shared_ok = pin_cfg_reg[lrs_pkg::SHARED_MASK_BIT]
                     | pin_reg[lrs_pkg::PIN_SHARED_GOOD];
  assign switch_one_ok = pin_cfg_reg[lrs_pkg::SWITCH_ONE_MASK_BIT]
                         | pin_reg[lrs_pkg::PIN_LOAD_SWITCH_B_ONE_GOOD];

  // Registered so the delay timer sees a clean, glitch-free level
  always_comb begin
    req_next = src_level & shared_ok & switch_one_ok;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
    end
  end

  // ----------------------------------------------------------------
  // Edge delays
  // ----------------------------------------------------------------
  logic [6:0] rise_ms, fall_ms, off_ms;

  assign rise_ms = lrs_pkg::lrs_edge_ms(
    dly_cfg_reg[lrs_pkg::RISE_LSB +: 3]);
  assign fall_ms = lrs_pkg::lrs_edge_ms(
    dly_cfg_reg[lrs_pkg::FALL_LSB +: 3]);
  assign off_ms = lrs_pkg::lrs_off_ms(
    dly_cfg_reg[lrs_pkg::OFF_TIME_LSB +: 2]);

  // Rail two follows the gated request after the edge delay
  lrs_edge_delay #(
    .MS_CYCLES(MS_CYCLES)
  ) u_ldo_two (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level_in(req_reg),
    .rise_ms(rise_ms),
    .fall_ms(fall_ms),
    .level_out(ldo_two_enable)
  );

  // Rail one drops at once; turn-on waits the off time, so the rail
  // stays down at least that long after any shutdown
  lrs_edge_delay #(
    .MS_CYCLES(MS_CYCLES)
  ) u_ldo_one (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level_in(pin_reg[lrs_pkg::PIN_LDO1_REQ]),
    .rise_ms(off_ms),
    .fall_ms(7'h00),
    .level_out(ldo_one_enable)
  );

  // ----------------------------------------------------------------
  // Rail three good qualification
  // ----------------------------------------------------------------
  logic [7:0] three_goods;
  logic three_ok_reg, three_ok_next;

  assign three_goods = {pin_reg[lrs_pkg::PIN_LDO2_GOOD],
                        pin_reg[lrs_pkg::PIN_SWA_GOOD],
                        pin_reg[lrs_pkg::PIN_STEP_LSB +: 6]};

  // Every unmasked flag must be high
  always_comb begin
    three_ok_next = &(three_goods | mask_cfg_reg);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      three_ok_reg <= 1'b0;
    end else begin
      three_ok_reg <= three_ok_next;
    end
  end

  assign ldo_three_goods_ok = three_ok_reg;

  // ----------------------------------------------------------------
  // Status view
  // ----------------------------------------------------------------
  always_comb begin
    status = 8'h00;
    status[lrs_pkg::STAT_LDO_TWO_BIT] = ldo_two_enable;
    status[lrs_pkg::STAT_LDO_ONE_BIT] = ldo_one_enable;
    status[lrs_pkg::STAT_LDO_THREE_OK_BIT] = three_ok_reg;
    status[lrs_pkg::STAT_REQ_BIT] = req_reg;
  end

endmodule : lrs_top

// >>> sim/lrs_top_props.sv
`timescale 1ns/100ps
// --------------------
// Port checker
// --------------------
module lrs_top_props #(
  parameter int MS_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] step_down_good,
  input wire logic switch_a_good,
  input wire logic ldo_two_good,
  input wire logic ldo_one_request,
  input wire logic ldo_two_enable,
  input wire logic ldo_one_enable,
  input wire logic ldo_three_goods_ok
);
  logic [15:0] hi_cnt_reg;
  logic [15:0] hi_cnt_next;
  logic [2:0] outs;

  assign outs = {ldo_three_goods_ok, ldo_one_enable, ldo_two_enable};

  // Request-high run length; reset parks it full so a rail
  // already on across reset is never flagged
  always_comb begin
    hi_cnt_next = hi_cnt_reg + 16'h0001;
    if (hi_cnt_reg == 16'hffff) hi_cnt_next = hi_cnt_reg;
    if (!ldo_one_request) hi_cnt_next = 16'h0000;
    if (sys_rst) hi_cnt_next = 16'hffff;
  end

  always_ff @(posedge core_clk) begin
    hi_cnt_reg <= hi_cnt_next;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst |=> outs == 3'h0) else $error("outputs kept in reset");
  goods_pass_a: assert property (
    (&{ldo_two_good, switch_a_good, step_down_good})[*4]
    |=> ldo_three_goods_ok) else $error("rail three flag low");
  shutdown_off_a: assert property (
    (!ldo_one_request)[*4] |=> !ldo_one_enable)
    else $error("rail one on in shutdown");
  off_time_a: assert property (
    $rose(ldo_one_enable) |-> hi_cnt_reg >= 16'(MS_CYCLES))
    else $error("rail one on before off time");
  status_map_a: assert property (
    reg_rd && reg_addr == 8'h30 |=> reg_rdata[2:0] == $past(outs))
    else $error("status differs from outputs");
  read_back_a: assert property (
    reg_wr && reg_addr inside {8'h1d, 8'h1e, 8'h1f} ##1 !reg_wr
    ##1 reg_rd && reg_addr == $past(reg_addr, 2)
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("bad readback");
  idle_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  unmapped_zero_a: assert property (
    reg_rd && !(reg_addr inside {8'h1d, 8'h1e, 8'h1f, 8'h30})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule : lrs_top_props

// >>> sim/tb_lrs_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_lrs_top;
  // --------------------
  // Signals and block
  // --------------------
  localparam int MSC = 4;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [5:0] control_input = 6'h00;
  logic [5:0] step_down_good = 6'h3f;
  logic shared_rail_good = 1'h1;
  logic switch_b_one_good = 1'h1;
  logic switch_a_good = 1'h1;
  logic ldo_two_good = 1'h1;
  logic ldo_one_request = 1'h0;
  logic ldo_two_enable;
  logic ldo_one_enable;
  logic ldo_three_goods_ok;
  int mismatches = 0;
  int checks = 0;
  int n;
  int ms [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  int om [4] = '{1, 5, 10, 100};
  int pm [8] = '{0, 1, 4, 3, 2, 0, 5, 0};

  lrs_top #(.MS_CYCLES(MSC)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .control_input(control_input),
    .shared_rail_good(shared_rail_good),
    .switch_b_one_good(switch_b_one_good),
    .step_down_good(step_down_good), .switch_a_good(switch_a_good),
    .ldo_two_good(ldo_two_good), .ldo_one_request(ldo_one_request),
    .ldo_two_enable(ldo_two_enable), .ldo_one_enable(ldo_one_enable),
    .ldo_three_goods_ok(ldo_three_goods_ok));

  always #25 core_clk = ~core_clk;

  // --------------------
  // Bus and timing tasks
  // --------------------
  // Ends 1 ns past the edge so outputs have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // Edges from a pin change until the chosen rail reaches lvl
  task automatic meas(input logic w, input logic lvl);
    n = 0;
    while ((w ? ldo_one_enable : ldo_two_enable) !== lvl && n < 600) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 600) begin
      mismatches++;
      end_of_test();
    end
  endtask : meas

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] rv [3];
    rv = '{8'h40, 8'h00, 8'h00};
    for (int i = 0; i < 3; i++) begin
      rd(8'h1d + 8'(i), d);
      `CHK("reset", rv[i], d)
      wr(8'h1d + 8'(i), 8'ha5 + 8'(i));
      rd(8'h1d + 8'(i), d);
      `CHK("readback", 8'ha5 + 8'(i), d)
    end
    rd(8'h55, d);
    `CHK("unmapped", 8'h00, d)
    $display("test regs done");
  endtask : t_regs

  // Every select code against single pins, pins 3+4, and none
  task automatic t_src();
    logic [5:0] p;
    logic e;
    wr(8'h1e, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(8'h1d, {3'h0, 3'(s), 2'h3});
      for (int i = 0; i < 8; i++) begin
        p = (i < 6) ? 6'h01 << i : (i == 6 ? 6'h0c : 6'h00);
        e = (s == 7) ? 1'h1 : (s == 5) ? (p[2] & p[3]) : p[pm[s]];
        @(posedge core_clk);
        control_input <= p;
        cyc(8);
        `CHK("source", e, ldo_two_enable)
      end
    end
    $display("test source done");
  endtask : t_src

  task automatic t_mask();
    logic [1:0] m;
    logic [1:0] g;
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      {m, g} = 4'(i);
      wr(8'h1d, 8'h1c | {6'h00, m});
      @(posedge core_clk);
      shared_rail_good <= g[1];
      switch_b_one_good <= g[0];
      cyc(8);
      `CHK("mask", (m[1] | g[1]) & (m[0] | g[0]), ldo_two_enable)
      rd(8'h30, d);
      `CHK("request", (m[1] | g[1]) & (m[0] | g[0]), d[3])
    end
    $display("test mask done");
  endtask : t_mask

  // Rise and fall use different codes so swapped fields show
  task automatic t_delay();
    wr(8'h1d, 8'h03);
    for (int c = 0; c < 8; c++) begin
      wr(8'h1e, {2'h0, 3'(7 - c), 3'(c)});
      @(posedge core_clk);
      control_input <= 6'h01;
      meas(1'h0, 1'h1);
      `CHK("rise", 4 + MSC * ms[c], n)
      @(posedge core_clk);
      control_input <= 6'h00;
      meas(1'h0, 1'h0);
      `CHK("fall", 4 + MSC * ms[7 - c], n)
    end
    $display("test delay done");
  endtask : t_delay

  task automatic t_off();
    for (int k = 0; k < 4; k++) begin
      wr(8'h1e, {2'(k), 6'h00});
      @(posedge core_clk);
      ldo_one_request <= 1'h1;
      meas(1'h1, 1'h1);
      @(posedge core_clk);
      ldo_one_request <= 1'h0;
      meas(1'h1, 1'h0);
      `CHK("off", 3, n)
      @(posedge core_clk);
      ldo_one_request <= 1'h1;
      meas(1'h1, 1'h1);
      `CHK("hold", 3 + MSC * om[k], n)
    end
    $display("test off time done");
  endtask : t_off

  task automatic t_three();
    logic [7:0] d;
    for (int b = 0; b < 8; b++) begin
      wr(8'h1f, 8'hff ^ (8'h01 << b));
      @(posedge core_clk);
      {ldo_two_good, switch_a_good, step_down_good} <= 8'hff ^ (8'h01 << b);
      cyc(5);
      `CHK("flag", 1'h0, ldo_three_goods_ok)
      wr(8'h1f, 8'hff);
      cyc(3);
      `CHK("flag", 1'h1, ldo_three_goods_ok)
      rd(8'h30, d);
      `CHK("status", 1'h1, d[2])
    end
    $display("test rail three done");
  endtask : t_three

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'h0;
    t_regs();
    t_src();
    t_mask();
    t_delay();
    t_off();
    t_three();
    end_of_test();
  end
endmodule : tb_lrs_top

bind lrs_top lrs_top_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .step_down_good(step_down_good),
  .switch_a_good(switch_a_good), .ldo_two_good(ldo_two_good),
  .ldo_one_request(ldo_one_request), .ldo_two_enable(ldo_two_enable),
  .ldo_one_enable(ldo_one_enable),
  .ldo_three_goods_ok(ldo_three_goods_ok));
